/* File: core/abort_syndrome_encoder.sv */
// Syndrome builder for instruction aborts, matrix traps and granule checks
// Functional notes
// - Abort cause in 6-bit field [5:0]; bit 6 held zero.
// - Address size fault levels 0..3 encode as 0x00..0x03.
// - Translation fault levels 0..3 encode as 0x04..0x07.
// - Access flag levels 1..3 as 0x09..0x0b; level 0 only with large addressing.
// - Permission levels 1..3 as 0x0d..0x0f; level 0 only with large addressing.
// - External abort off a walk encodes 0x10.
// - External abort on walk levels 0..3 as 0x14..0x17; level -1 0x13.
// - Parity errors only without reliability extension: 0x18, 0x1c..0x1f, 0x1b.
// - Granule faults with realm extension: 0x24..0x27, 0x23, 0x28 off walk.
// - With large addressing, level -1 address size 0x29, translation 0x2b.
// - TLB conflict 0x30; atomic update fault 0x31 only with that feature.
// - Unlisted codes are reserved and never produced.
// - Access flag and permission faults not reported at level 0 otherwise.
// - With stage-1-walk flag, level reported is the stage 2 lookup level.
// - Fields may hold unknown values after warm reset.
// - Matrix trap reason in bits [1:0]; bits [24:2] zero.
// - Code 0 for enable/trap control block, unless class is zero.
// - Code 1 for vector instruction trapped with streaming mode on.
// - Code 2 when streaming mode off, code 3 when matrix storage off.
// - Matrix traps use exception class 0x1d.
// - Granule syndrome bits [24:22] zero; bit 21 flags stage 2 walk.
// - Bit 20 set for instruction access; status code in [19:14].
// - Granule status codes: 0x00/01, 0x04/05, 0x0c/0d, 0x14/15 by level.
`timescale 1ns/1ns
`include "abort_syndrome_cfg.svh"
module abort_syndrome_encoder (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              clk_en,
  // Implemented features
  input  wire logic                              large_phys_addr_feature,
  input  wire logic                              reliability_extension_feature,
  input  wire logic                              realm_extension_feature,
  input  wire logic                              hw_flag_dirty_update_feature,
  // Instruction abort event
  input  wire logic                              abort_valid,
  input  wire abort_syndrome_pkg::fault_kind_t   abort_kind,
  input  wire logic                              abort_on_walk,
  input  wire logic [1:0]                        abort_level,
  input  wire logic                              abort_level_m1,
  input  wire logic                              stage1_walk_via_stage2_flag,
  input  wire logic [1:0]                        stage2_level,
  input  wire logic                              stage2_level_m1,
  // Matrix trap event
  input  wire logic                              trap_valid,
  input  wire abort_syndrome_pkg::trap_kind_t    trap_kind,
  input  wire logic                              streaming_mode_bit,
  input  wire logic                              matrix_storage_enable_bit,
  input  wire logic                              trap_unknown_class,
  // Granule check event
  input  wire logic                              gpc_valid,
  input  wire abort_syndrome_pkg::gpc_kind_t     gpc_kind,
  input  wire logic                              gpc_level,
  input  wire logic                              stage2_walk_flag,
  input  wire logic                              instr_not_data_flag,
  // Syndrome output
  output logic                                   syn_valid,
  output abort_syndrome_pkg::syn_kind_t          syn_kind,
  output logic [`SYN_W-1:0]                      syndrome,
  output logic [`CLASS_W-1:0]                    exception_class,
  output logic                                   code_illegal
);
  // ---------------------------------------------------------------
  // Fault status encoding
  // ---------------------------------------------------------------
  logic [1:0]       eff_level;
  logic             eff_m1;
  logic [`FSC_W-1:0] instr_fault_status_code;
  logic             fsc_legal;

  assign eff_level = stage1_walk_via_stage2_flag ? stage2_level : abort_level;
  assign eff_m1    = stage1_walk_via_stage2_flag ? stage2_level_m1 : abort_level_m1;

  fault_code_encoder fault_code_encoder_inst (
    .kind                          (abort_kind),
    .on_walk                       (abort_on_walk),
    .level                         (eff_level),
    .level_m1                      (eff_m1),
    .large_phys_addr_feature       (large_phys_addr_feature),
    .reliability_extension_feature (reliability_extension_feature),
    .realm_extension_feature       (realm_extension_feature),
    .hw_flag_dirty_update_feature  (hw_flag_dirty_update_feature),
    .code                          (instr_fault_status_code),
    .legal                         (fsc_legal)
  );

  // ---------------------------------------------------------------
  // Trap reason and granule status
  // ---------------------------------------------------------------
  logic [`TRAP_RSN_W-1:0] matrix_trap_reason_code;
  logic                   trap_legal;
  logic [`FSC_W-1:0]      granule_check_status_code;

  always_comb begin
    matrix_trap_reason_code = `TRAP_CTRL;
    trap_legal              = 1'b0;
    case (trap_kind)
      abort_syndrome_pkg::tk_ctrl: begin
        matrix_trap_reason_code = `TRAP_CTRL;
        trap_legal              = !trap_unknown_class;
      end
      abort_syndrome_pkg::tk_sm_on: begin
        matrix_trap_reason_code = `TRAP_SM_ON;
        trap_legal              = streaming_mode_bit;
      end
      abort_syndrome_pkg::tk_sm_off: begin
        matrix_trap_reason_code = `TRAP_SM_OFF;
        trap_legal              = !streaming_mode_bit;
      end
      abort_syndrome_pkg::tk_za_off: begin
        matrix_trap_reason_code = `TRAP_ZA_OFF;
        trap_legal              = !matrix_storage_enable_bit;
      end
      default: begin
        matrix_trap_reason_code = `TRAP_CTRL;
        trap_legal              = 1'b0;
      end
    endcase
  end

  function automatic logic [`FSC_W-1:0] gsc_at(input logic [`FSC_W-1:0] base, input logic lvl);
    gsc_at = base | {5'h00, lvl};
  endfunction

  always_comb begin
    case (gpc_kind)
      abort_syndrome_pkg::gk_addr_size: granule_check_status_code = gsc_at(`GSC_ADDR_SIZE, gpc_level);
      abort_syndrome_pkg::gk_walk:      granule_check_status_code = gsc_at(`GSC_WALK, gpc_level);
      abort_syndrome_pkg::gk_prot:      granule_check_status_code = gsc_at(`GSC_PROT, gpc_level);
      abort_syndrome_pkg::gk_ext:       granule_check_status_code = gsc_at(`GSC_EXT, gpc_level);
      default:                          granule_check_status_code = `GSC_ADDR_SIZE;
    endcase
  end

  // ---------------------------------------------------------------
  // Syndrome register
  // ---------------------------------------------------------------
  logic                            next_syn_valid;
  abort_syndrome_pkg::syn_kind_t   next_syn_kind;
  logic [`SYN_W-1:0]               next_syndrome;
  logic [`CLASS_W-1:0]             next_exception_class;
  logic                            next_code_illegal;

  // Priority: abort, then granule check, then matrix trap
  always_comb begin
    next_syn_valid       = 1'b0;
    next_syn_kind        = syn_kind;
    next_syndrome        = syndrome;
    next_exception_class = exception_class;
    next_code_illegal    = code_illegal;
    if (abort_valid) begin
      next_syn_valid    = fsc_legal;
      next_syn_kind     = abort_syndrome_pkg::sk_abort;
      next_syndrome     = '0;
      next_syndrome[`FSC_W-1:`FSC_LSB] = instr_fault_status_code;
      next_code_illegal = !fsc_legal;
    end else if (gpc_valid) begin
      next_syn_valid    = 1'b1;
      next_syn_kind     = abort_syndrome_pkg::sk_gpc;
      next_syndrome     = '0;
      next_syndrome[`GPC_S2W_BIT] = stage2_walk_flag;
      next_syndrome[`GPC_INSTR_BIT] = instr_not_data_flag;
      next_syndrome[`GPC_SC_LSB +: `FSC_W] = granule_check_status_code;
      next_code_illegal = 1'b0;
    end else if (trap_valid) begin
      next_syn_valid       = trap_legal;
      next_syn_kind        = abort_syndrome_pkg::sk_trap;
      next_syndrome        = '0;
      next_syndrome[`TRAP_RSN_W-1:0] = matrix_trap_reason_code;
      next_exception_class = `CLASS_MATRIX;
      next_code_illegal    = !trap_legal;
    end
  end

  // Reset values are a convenience; fields are unknown after warm reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syn_valid       <= 1'b0;
      syn_kind        <= abort_syndrome_pkg::sk_none;
      syndrome        <= '0;
      exception_class <= `CLASS_NONE;
      code_illegal    <= 1'b0;
    end else if (clk_en) begin
      syn_valid       <= next_syn_valid;
      syn_kind        <= next_syn_kind;
      syndrome        <= next_syndrome;
      exception_class <= next_exception_class;
      code_illegal    <= next_code_illegal;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Event taken at this edge, after priority
  logic abort_take;
  logic gpc_take;
  logic trap_take;

  assign abort_take = clk_en && abort_valid;
  assign gpc_take   = clk_en && !abort_valid && gpc_valid;
  assign trap_take  = clk_en && !abort_valid && !gpc_valid && trap_valid;

  abort_bit6_zero_a: assert property (
    syn_valid && syn_kind == abort_syndrome_pkg::sk_abort
    |-> syndrome[`SYN_W-1:`FSC_RSV_BIT] == '0)
    else $error("abort syndrome upper bits not zero");
  abort_asz_code_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_addr_size && !eff_m1
    |=> syndrome[`FSC_W-1:0] == (`FSC_ADDR_SIZE | {4'h0, $past(eff_level)}))
    else $error("address size fault code wrong");
  abort_xlat_code_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_xlat && !eff_m1
    |=> syndrome[`FSC_W-1:0] == (`FSC_XLAT | {4'h0, $past(eff_level)}))
    else $error("translation fault code wrong");
  abort_acc_code_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_acc_flag && !eff_m1 && eff_level != 2'h0
    |=> syn_valid && syndrome[`FSC_W-1:0] == (`FSC_ACC_FLAG | {4'h0, $past(eff_level)}))
    else $error("access flag fault code wrong");
  abort_perm_code_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_perm && !eff_m1 && eff_level != 2'h0
    |=> syn_valid && syndrome[`FSC_W-1:0] == (`FSC_PERM | {4'h0, $past(eff_level)}))
    else $error("permission fault code wrong");
  abort_ext_nw_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_ext && !abort_on_walk
    |=> syn_valid && syndrome[`FSC_W-1:0] == `FSC_EXT_NW)
    else $error("external abort code wrong");
  abort_ext_walk_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_ext && abort_on_walk
    |=> syn_valid == (!$past(eff_m1) || $past(large_phys_addr_feature)))
    else $error("walk external abort wrongly gated");
  abort_par_ras_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_par && reliability_extension_feature
    |=> !syn_valid && code_illegal)
    else $error("parity code produced with reliability extension");
  abort_gpf_nw_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_gpf && !abort_on_walk && realm_extension_feature
    |=> syn_valid && syndrome[`FSC_W-1:0] == `FSC_GPF_NW)
    else $error("granule fault off walk code wrong");
  abort_xlt_m1_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_xlat && eff_m1 && large_phys_addr_feature
    |=> syn_valid && syndrome[`FSC_W-1:0] == `FSC_XLT_M1)
    else $error("level -1 translation fault code wrong");
  abort_tlb_code_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_tlb_conf
    |=> syn_valid && syndrome[`FSC_W-1:0] == `FSC_TLB_CONF)
    else $error("conflict abort code wrong");
  abort_atom_hw_a: assert property (
    abort_take && abort_kind == abort_syndrome_pkg::fk_atom_hw
    |=> syn_valid == $past(hw_flag_dirty_update_feature))
    else $error("atomic update fault wrongly gated");
  abort_one_flag_a: assert property (
    abort_take |=> syn_valid != code_illegal)
    else $error("abort valid and illegal flags disagree");
  abort_lvl0_acc_a: assert property (
    syn_valid && syn_kind == abort_syndrome_pkg::sk_abort && !large_phys_addr_feature
    |-> syndrome[`FSC_W-1:0] != `FSC_ACC_FLAG && syndrome[`FSC_W-1:0] != `FSC_PERM)
    else $error("level 0 access or permission fault without feature");
  abort_s2_level_a: assert property (
    abort_take && stage1_walk_via_stage2_flag && !stage2_level_m1
    && (abort_kind == abort_syndrome_pkg::fk_addr_size || abort_kind == abort_syndrome_pkg::fk_xlat)
    |=> syndrome[1:0] == $past(stage2_level))
    else $error("stage 2 level not used");

  trap_upper_zero_a: assert property (
    syn_valid && syn_kind == abort_syndrome_pkg::sk_trap
    |-> syndrome[`SYN_W-1:`TRAP_RSN_W] == '0 && exception_class == `CLASS_MATRIX)
    else $error("matrix trap syndrome malformed");
  trap_ctrl_code_a: assert property (
    trap_take && trap_kind == abort_syndrome_pkg::tk_ctrl
    |=> syn_valid == !$past(trap_unknown_class) && syndrome[`TRAP_RSN_W-1:0] == `TRAP_CTRL)
    else $error("control trap code wrong");
  trap_sm_code_a: assert property (
    trap_take && trap_kind == abort_syndrome_pkg::tk_sm_on && streaming_mode_bit
    |=> syn_valid && syndrome[`TRAP_RSN_W-1:0] == `TRAP_SM_ON)
    else $error("streaming vector trap code wrong");
  trap_za_code_a: assert property (
    trap_take && trap_kind == abort_syndrome_pkg::tk_za_off && !matrix_storage_enable_bit
    |=> syndrome[`TRAP_RSN_W-1:0] == `TRAP_ZA_OFF)
    else $error("matrix storage trap code wrong");

  gpc_fields_a: assert property (
    gpc_take |=> syndrome[`SYN_W-1:`GPC_S2W_BIT+1] == '0 && syndrome[`GPC_S2W_BIT] == $past(stage2_walk_flag)
    && syndrome[`GPC_INSTR_BIT] == $past(instr_not_data_flag))
    else $error("granule check flags wrong");
  gpc_code_a: assert property (
    gpc_take && gpc_kind == abort_syndrome_pkg::gk_ext
    |=> syndrome[`GPC_SC_LSB +: `FSC_W] == (`GSC_EXT | {5'h00, $past(gpc_level)}))
    else $error("granule status code wrong");

  cover_abort_c: cover property (syn_valid && syn_kind == abort_syndrome_pkg::sk_abort);
  cover_trap_c:  cover property (syn_valid && syn_kind == abort_syndrome_pkg::sk_trap);
  cover_gpc_c:   cover property (syn_valid && syn_kind == abort_syndrome_pkg::sk_gpc);
  cover_bad_c:   cover property (code_illegal);
  cover_s2_c:    cover property (abort_take && stage1_walk_via_stage2_flag);
endmodule

/* File: core/abort_syndrome_cfg.svh */
// Syndrome field positions, fault codes, trap codes and class values
`ifndef ABORT_SYNDROME_CFG_SVH
`define ABORT_SYNDROME_CFG_SVH
// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define SYN_W          25
`define FSC_W          6
`define FSC_LSB        0
`define FSC_RSV_BIT    6
`define TRAP_RSN_W     2
`define GPC_S2W_BIT    21
`define GPC_INSTR_BIT  20
`define GPC_SC_LSB     14
`define CLASS_W        6
// ---------------------------------------------------------------
// Fault status codes (level added to per-level bases)
// ---------------------------------------------------------------
`define FSC_ADDR_SIZE  6'h00
`define FSC_XLAT       6'h04
`define FSC_ACC_FLAG   6'h08
`define FSC_PERM       6'h0c
`define FSC_EXT_NW     6'h10
`define FSC_EXT_WM1    6'h13
`define FSC_EXT_W      6'h14
`define FSC_PAR_NW     6'h18
`define FSC_PAR_WM1    6'h1b
`define FSC_PAR_W      6'h1c
`define FSC_GPF_WM1    6'h23
`define FSC_GPF_W      6'h24
`define FSC_GPF_NW     6'h28
`define FSC_ASZ_M1     6'h29
`define FSC_XLT_M1     6'h2b
`define FSC_TLB_CONF   6'h30
`define FSC_ATOM_HW    6'h31
// ---------------------------------------------------------------
// Granule check status bases, matrix trap codes, classes
// ---------------------------------------------------------------
`define GSC_ADDR_SIZE  6'h00
`define GSC_WALK       6'h04
`define GSC_PROT       6'h0c
`define GSC_EXT        6'h14
`define TRAP_CTRL      2'h0
`define TRAP_SM_ON     2'h1
`define TRAP_SM_OFF    2'h2
`define TRAP_ZA_OFF    2'h3
`define CLASS_NONE     6'h00
`define CLASS_MATRIX   6'h1d
`endif

/* File: core/abort_syndrome_pkg.sv */
// Types shared by the syndrome encoder
package abort_syndrome_pkg;
  typedef enum logic [3:0] {
    fk_addr_size, fk_xlat, fk_acc_flag, fk_perm, fk_ext, fk_par, fk_gpf, fk_tlb_conf, fk_atom_hw
  } fault_kind_t;
  typedef enum logic [1:0] {
    tk_ctrl, tk_sm_on, tk_sm_off, tk_za_off
  } trap_kind_t;
  typedef enum logic [1:0] {
    gk_addr_size, gk_walk, gk_prot, gk_ext
  } gpc_kind_t;
  typedef enum logic [1:0] {
    sk_none, sk_abort, sk_trap, sk_gpc
  } syn_kind_t;
endpackage

/* File: core/fault_code_encoder.sv */
// Combinational instruction fault status encoder
`timescale 1ns/1ns
`include "abort_syndrome_cfg.svh"
module fault_code_encoder (
  // Fault classification
  input  wire abort_syndrome_pkg::fault_kind_t kind,
  input  wire logic                            on_walk,
  input  wire logic [1:0]                      level,
  input  wire logic                            level_m1,
  // Implemented features
  input  wire logic                            large_phys_addr_feature,
  input  wire logic                            reliability_extension_feature,
  input  wire logic                            realm_extension_feature,
  input  wire logic                            hw_flag_dirty_update_feature,
  // Result
  output logic [`FSC_W-1:0]                    code,
  output logic                                 legal
);
  function automatic logic [`FSC_W-1:0] at_level(input logic [`FSC_W-1:0] base, input logic [1:0] lvl);
    at_level = base | {4'h0, lvl};
  endfunction

  logic lpa_m1;
  logic [1:0] lvl;

  always_comb begin
    lvl    = level;
    lpa_m1 = level_m1 & large_phys_addr_feature;
    code   = `FSC_TLB_CONF;
    legal  = 1'b0;
    case (kind)
      abort_syndrome_pkg::fk_addr_size: begin
        code  = level_m1 ? `FSC_ASZ_M1 : at_level(`FSC_ADDR_SIZE, lvl);
        legal = !level_m1 || lpa_m1;
      end
      abort_syndrome_pkg::fk_xlat: begin
        code  = level_m1 ? `FSC_XLT_M1 : at_level(`FSC_XLAT, lvl);
        legal = !level_m1 || lpa_m1;
      end
      abort_syndrome_pkg::fk_acc_flag: begin
        code  = at_level(`FSC_ACC_FLAG, lvl);
        legal = !level_m1 && (lvl != 2'h0 || large_phys_addr_feature);
      end
      abort_syndrome_pkg::fk_perm: begin
        code  = at_level(`FSC_PERM, lvl);
        legal = !level_m1 && (lvl != 2'h0 || large_phys_addr_feature);
      end
      abort_syndrome_pkg::fk_ext: begin
        code  = !on_walk ? `FSC_EXT_NW : (level_m1 ? `FSC_EXT_WM1 : at_level(`FSC_EXT_W, lvl));
        legal = !on_walk || !level_m1 || lpa_m1;
      end
      abort_syndrome_pkg::fk_par: begin
        code  = !on_walk ? `FSC_PAR_NW : (level_m1 ? `FSC_PAR_WM1 : at_level(`FSC_PAR_W, lvl));
        legal = !reliability_extension_feature && (!on_walk || !level_m1 || lpa_m1);
      end
      abort_syndrome_pkg::fk_gpf: begin
        code  = !on_walk ? `FSC_GPF_NW : (level_m1 ? `FSC_GPF_WM1 : at_level(`FSC_GPF_W, lvl));
        legal = realm_extension_feature && (!on_walk || !level_m1 || lpa_m1);
      end
      abort_syndrome_pkg::fk_tlb_conf: begin
        code  = `FSC_TLB_CONF;
        legal = 1'b1;
      end
      abort_syndrome_pkg::fk_atom_hw: begin
        code  = `FSC_ATOM_HW;
        legal = hw_flag_dirty_update_feature;
      end
      default: begin
        code  = `FSC_TLB_CONF;
        legal = 1'b0;
      end
    endcase
  end
endmodule

/* File: verification/abort_syndrome_encoder_tb.sv */
// Self-checking testbench for the syndrome builder
`timescale 1ns/1ns
module abort_syndrome_encoder_tb;
  logic clk, resetn, clk_en;
  logic large_phys_addr_feature, reliability_extension_feature, realm_extension_feature, hw_flag_dirty_update_feature;
  logic abort_valid, abort_on_walk, abort_level_m1, stage1_walk_via_stage2_flag, stage2_level_m1;
  logic [1:0] abort_level, stage2_level;
  abort_syndrome_pkg::fault_kind_t abort_kind;
  logic trap_valid, streaming_mode_bit, matrix_storage_enable_bit, trap_unknown_class;
  abort_syndrome_pkg::trap_kind_t trap_kind;
  logic gpc_valid, gpc_level, stage2_walk_flag, instr_not_data_flag;
  abort_syndrome_pkg::gpc_kind_t gpc_kind;
  logic syn_valid, code_illegal;
  abort_syndrome_pkg::syn_kind_t syn_kind;
  logic [24:0] syndrome;
  logic [5:0] exception_class;
  int err_total = 0;
  int n_compared = 0;
  logic [6:0] e;

  abort_syndrome_encoder abort_syndrome_encoder_inst (
    .clk, .resetn, .clk_en, .large_phys_addr_feature, .reliability_extension_feature, .realm_extension_feature,
    .hw_flag_dirty_update_feature, .abort_valid, .abort_kind, .abort_on_walk, .abort_level, .abort_level_m1,
    .stage1_walk_via_stage2_flag, .stage2_level, .stage2_level_m1, .trap_valid, .trap_kind, .streaming_mode_bit,
    .matrix_storage_enable_bit, .trap_unknown_class, .gpc_valid, .gpc_kind, .gpc_level, .stage2_walk_flag,
    .instr_not_data_flag, .syn_valid, .syn_kind, .syndrome, .exception_class, .code_illegal
  );

  // ---------------------------------------------------------------
  // Clock, checking and verdict
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Lets the taking edge pass, then checks the one-cycle answer
  task automatic take(input logic ok, input logic [24:0] msk, input logic [24:0] exp,
                      input abort_syndrome_pkg::syn_kind_t k);
    @(negedge clk);
    chk(syn_valid, ok, "valid");
    chk(code_illegal, !ok, "illegal flag");
    if (ok) begin
      chk(syndrome & msk, exp, "syndrome");
      chk(syn_kind, k, "kind");
    end
  endtask

  task automatic idle;
    abort_valid = 1'b0;
    trap_valid = 1'b0;
    gpc_valid = 1'b0;
    @(negedge clk);
    chk(syn_valid, 1'b0, "valid after idle");
  endtask

  task automatic feats(input logic lpa, rel, rlm, hw);
    large_phys_addr_feature = lpa;
    reliability_extension_feature = rel;
    realm_extension_feature = rlm;
    hw_flag_dirty_update_feature = hw;
  endtask

  // Level index 4 stands for level -1
  function automatic logic [6:0] exp_fsc(int k, int w, int l);
    logic [5:0] b;
    logic ok;
    logic m1;
    logic lpa;
    m1 = (l == 4);
    lpa = large_phys_addr_feature;
    ok = !m1 || w == 0 || lpa;
    case (k)
      0: b = m1 ? 6'h29 : 6'(l);
      1: b = m1 ? 6'h2b : 6'h04 + 6'(l);
      2, 3: begin
        b = (k == 2 ? 6'h08 : 6'h0c) + 6'(l);
        ok = !m1 && (l != 0 || lpa);
      end
      4: b = w == 0 ? 6'h10 : m1 ? 6'h13 : 6'h14 + 6'(l);
      5: begin
        b = w == 0 ? 6'h18 : m1 ? 6'h1b : 6'h1c + 6'(l);
        ok = ok && !reliability_extension_feature;
      end
      6: begin
        b = w == 0 ? 6'h28 : m1 ? 6'h23 : 6'h24 + 6'(l);
        ok = ok && realm_extension_feature;
      end
      7: begin
        b = 6'h30;
        ok = 1'b1;
      end
      default: begin
        b = 6'h31;
        ok = hw_flag_dirty_update_feature;
      end
    endcase
    return {ok, b};
  endfunction

  task automatic abort_ev(input int k, w, l);
    abort_valid = 1'b1;
    abort_kind = abort_syndrome_pkg::fault_kind_t'(k);
    abort_on_walk = 1'(w);
    abort_level = (l == 4) ? 2'h0 : 2'(l);
    abort_level_m1 = (l == 4);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0; clk_en = 1'b1; feats(1'b1, 1'b0, 1'b1, 1'b1);
    abort_valid = 1'b0; abort_kind = abort_syndrome_pkg::fk_xlat; abort_on_walk = 1'b0; abort_level = 2'h0;
    abort_level_m1 = 1'b0; stage1_walk_via_stage2_flag = 1'b0; stage2_level = 2'h0; stage2_level_m1 = 1'b0;
    trap_valid = 1'b0; trap_kind = abort_syndrome_pkg::tk_ctrl; streaming_mode_bit = 1'b0;
    matrix_storage_enable_bit = 1'b1; trap_unknown_class = 1'b0;
    gpc_valid = 1'b0; gpc_kind = abort_syndrome_pkg::gk_walk; gpc_level = 1'b0;
    stage2_walk_flag = 1'b0; instr_not_data_flag = 1'b0;
    repeat (3) @(negedge clk);
    chk({syn_valid, code_illegal, syn_kind, exception_class}, 25'h0, "reset outputs");
    resetn = 1'b1;
    // Every fault kind, walk flag and level (level -1 on walk only), back to back, under two feature sets
    for (int f = 0; f < 2; f++) begin
      if (f == 1) feats(1'b0, 1'b1, 1'b0, 1'b0);
      for (int k = 0; k < 9; k++)
        for (int w = 0; w < 2; w++)
          for (int l = 0; l < 5; l++)
            if (l < 4 || w == 1) begin
              abort_ev(k, w, l);
              e = exp_fsc(k, w, l);
              take(e[6], 25'h7f, {19'h0, e[5:0]}, abort_syndrome_pkg::sk_abort);
            end
      idle();
    end
    $display("test fault code table done");
    // Stage 2 level replaces the walk level
    feats(1'b1, 1'b0, 1'b1, 1'b1);
    stage1_walk_via_stage2_flag = 1'b1; stage2_level = 2'h3;
    abort_ev(1, 0, 1);
    take(1'b1, 25'h7f, 25'h07, abort_syndrome_pkg::sk_abort);
    stage1_walk_via_stage2_flag = 1'b0;
    idle();
    $display("test stage 2 level done");
    // Matrix trap reasons, back to back
    for (int t = 0; t < 4; t++) begin
      trap_valid = 1'b1;
      trap_kind = abort_syndrome_pkg::trap_kind_t'(t);
      streaming_mode_bit = (t == 1);
      matrix_storage_enable_bit = (t != 3);
      take(1'b1, 25'h1ffffff, 25'(t), abort_syndrome_pkg::sk_trap);
      chk(exception_class, 6'h1d, "trap class");
    end
    trap_kind = abort_syndrome_pkg::tk_ctrl; trap_unknown_class = 1'b1;
    take(1'b0, 25'h0, 25'h0, abort_syndrome_pkg::sk_trap);
    trap_unknown_class = 1'b0; trap_kind = abort_syndrome_pkg::tk_sm_on; streaming_mode_bit = 1'b0;
    take(1'b0, 25'h0, 25'h0, abort_syndrome_pkg::sk_trap);
    idle();
    $display("test matrix traps done");
    // Granule checks: every kind, level and stage 2 walk flag; instruction flag fixed per kind
    for (int g = 0; g < 16; g++) begin
      gpc_valid = 1'b1;
      gpc_kind = abort_syndrome_pkg::gpc_kind_t'(g >> 2);
      gpc_level = g[0];
      stage2_walk_flag = g[1];
      instr_not_data_flag = g[2] ^ g[3];
      e = {1'b0, (g >> 2) == 0 ? 6'h00 : (g >> 2) == 1 ? 6'h04 : (g >> 2) == 2 ? 6'h0c : 6'h14};
      take(1'b1, 25'h1ffc000, {3'h0, g[1], g[2] ^ g[3], e[5:0] + 6'(g[0]), 14'h0},
           abort_syndrome_pkg::sk_gpc);
    end
    chk(exception_class, 6'h1d, "class held");
    // Abort wins over simultaneous granule check and trap
    trap_valid = 1'b1; trap_kind = abort_syndrome_pkg::tk_ctrl;
    abort_ev(7, 0, 0);
    take(1'b1, 25'h7f, 25'h30, abort_syndrome_pkg::sk_abort);
    idle();
    $display("test granule checks done");
    // Frozen clock enable takes nothing; reset in mid-run clears outputs
    clk_en = 1'b0;
    abort_ev(0, 0, 2);
    @(negedge clk);
    chk(syn_valid, 1'b0, "frozen");
    clk_en = 1'b1;
    take(1'b1, 25'h7f, 25'h02, abort_syndrome_pkg::sk_abort);
    abort_valid = 1'b0;
    resetn = 1'b0;
    #1;
    chk({syn_valid, code_illegal, syn_kind, exception_class}, 25'h0, "mid-run reset");
    @(negedge clk);
    resetn = 1'b1;
    $display("test enable and reset done");
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
